// ---- src/alcc_pkg.sv ----
// Package: register map, field layout, timing and types of the light comparator block
package alcc_pkg;

    localparam logic [7:0]  ALCC_OFS_CFG_A    = 8'h1B;
    localparam logic [7:0]  ALCC_OFS_CFG_B    = 8'h1C;
    localparam logic [7:0]  ALCC_CFG_RESET    = 8'h00;
    localparam logic [7:0]  ALCC_RDATA_UNMAP  = 8'h00;

    // Bit positions inside each configuration byte
    localparam int          ALCC_POS_FILTER_TIME_SEL_A_LO  = 5;
    localparam int          ALCC_POS_FORCE    = 4;
    localparam int          ALCC_POS_DARK_OUT = 3;
    localparam int          ALCC_POS_OFF_OUT  = 2;
    localparam int          ALCC_POS_DARK_EN  = 1;
    localparam int          ALCC_POS_OFF_EN   = 0;

    localparam int          ALCC_NUM_CH       = 2;
    localparam int          ALCC_RES_W        = 13;
    localparam int          ALCC_ACC_W        = 20;
    localparam int          ALCC_THR_W        = 8;
    localparam int          ALCC_TICK_W       = 24;

    // Base sample period and its length in clock cycles
    localparam int          ALCC_CLK_HZ       = 125_000_000;
    localparam int          ALCC_PERIOD_MS    = 80;
    localparam int          ALCC_PERIOD_CYC   = ALCC_PERIOD_MS * (ALCC_CLK_HZ / 1000);

    typedef enum logic [1:0] {
        ALCC_LVL_DAYLIGHT = 2'b01,
        ALCC_LVL_OFFICE   = 2'b10,
        ALCC_LVL_DARK     = 2'b11
    } alcc_level_e;

    // Same bit order as the configuration byte
    typedef struct packed {
        logic [2:0] filter_time_sel_a;
        logic       force_req;
        logic       dark_out;
        logic       office_out;
        logic       dark_en;
        logic       office_en;
    } alcc_cfg_s;

    typedef struct packed {
        logic [ALCC_THR_W-1:0] office_threshold;
        logic [ALCC_THR_W-1:0] office_hysteresis;
        logic [ALCC_THR_W-1:0] dark_threshold;
        logic [ALCC_THR_W-1:0] dark_hysteresis;
    } alcc_thr_s;

    localparam alcc_thr_s   ALCC_THR_RESET    = '0;

endpackage : alcc_pkg

// ---- src/alcc_channel.sv ----
// One sensor channel: filter, forced conversion and dark/office comparators
`timescale 1ns/1ns
module alcc_channel
    import alcc_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic                  tick,
    input  wire logic                  cfg_wr,
    input  wire alcc_pkg::alcc_cfg_s   cfg_wdata,
    input  wire alcc_pkg::alcc_thr_s   thr,
    input  wire logic [12:0]           light_sensor_input,
    input  wire logic                  sensor_enable,
    input  wire logic                  sinks_active,
    input  wire logic                  backlight_enable,
    output alcc_pkg::alcc_cfg_s        cfg,
    output logic [12:0]                conv_result,
    output alcc_pkg::alcc_level_e      level
);
    import alcc_pkg::*;

    typedef struct packed {
        alcc_cfg_s              cfg;
        logic [7:0]             samples;
        logic [ALCC_ACC_W-1:0]  accum;
        logic [ALCC_RES_W-1:0]  result;
        logic                   dark_trip;
        logic                   office_trip;
        alcc_level_e            level;
    } alcc_ch_state_s;

    alcc_ch_state_s s;
    alcc_ch_state_s next_s;

    logic [ALCC_ACC_W-1:0] acc_sum;
    logic [7:0]            window;
    logic                  conv_done;
    logic [ALCC_RES_W-1:0] conv_val;
    logic [ALCC_RES_W-1:0] dark_lo;
    logic [ALCC_RES_W-1:0] dark_hi;
    logic [ALCC_RES_W-1:0] off_lo;
    logic [ALCC_RES_W-1:0] off_hi;

    always_comb begin
        next_s    = s;
        acc_sum   = s.accum + ALCC_ACC_W'(light_sensor_input);
        window    = 8'h01 << s.cfg.filter_time_sel_a;
        conv_done = 1'b0;
        conv_val  = s.result;
        dark_lo   = ALCC_RES_W'(thr.dark_threshold);
        dark_hi   = ALCC_RES_W'(thr.dark_threshold) + ALCC_RES_W'(thr.dark_hysteresis);
        off_lo    = ALCC_RES_W'(thr.office_threshold);
        off_hi    = ALCC_RES_W'(thr.office_threshold) + ALCC_RES_W'(thr.office_hysteresis);

        // Filter window: one sample per 80 ms, averaged over 2^filter_time_sel_a samples
        if (sensor_enable && tick) begin
            if (s.samples + 8'h01 >= window) begin
                conv_done      = 1'b1;
                conv_val       = ALCC_RES_W'(acc_sum >> s.cfg.filter_time_sel_a);
                next_s.samples = 8'h00;
                next_s.accum   = '0;
            end else begin
                next_s.samples = s.samples + 8'h01;
                next_s.accum   = acc_sum;
            end
        end

        // Forced read: single-sample conversion, request then retires
        if (s.cfg.force_req) begin
            if (backlight_enable) begin
                next_s.cfg.force_req = 1'b0;
            end else if (sinks_active) begin
                conv_done            = 1'b1;
                conv_val             = light_sensor_input;
                next_s.cfg.force_req = 1'b0;
            end
        end

        if (conv_done) begin
            next_s.result = conv_val;
            if (conv_val < dark_lo) begin
                next_s.dark_trip = 1'b1;
            end else if (conv_val > dark_hi) begin
                next_s.dark_trip = 1'b0;
            end
            if (conv_val < off_lo) begin
                next_s.office_trip = 1'b1;
            end else if (conv_val > off_hi) begin
                next_s.office_trip = 1'b0;
            end
        end

        // Software write; a set of the request wins over the hardware clear
        if (cfg_wr) begin
            next_s.cfg.filter_time_sel_a      = cfg_wdata.filter_time_sel_a;
            next_s.cfg.dark_en   = cfg_wdata.dark_en;
            next_s.cfg.office_en = cfg_wdata.office_en;
            if (cfg_wdata.force_req) begin
                next_s.cfg.force_req = 1'b1;
            end
            // Restart the window so a shorter filter cannot skip its end
            next_s.samples = 8'h00;
            next_s.accum   = '0;
        end

        // Disabled comparator is held untripped
        if (!next_s.cfg.dark_en) begin
            next_s.dark_trip = 1'b0;
        end
        if (!next_s.cfg.office_en) begin
            next_s.office_trip = 1'b0;
        end
        next_s.cfg.dark_out   = next_s.dark_trip;
        next_s.cfg.office_out = next_s.office_trip;

        if (next_s.dark_trip) begin
            next_s.level = ALCC_LVL_DARK;
        end else if (next_s.office_trip) begin
            next_s.level = ALCC_LVL_OFFICE;
        end else begin
            next_s.level = ALCC_LVL_DAYLIGHT;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s       <= '0;
            s.cfg   <= ALCC_CFG_RESET;
            s.level <= ALCC_LVL_DAYLIGHT;
        end else begin
            s <= next_s;
        end
    end

    assign cfg         = s.cfg;
    assign conv_result = s.result;
    assign level       = s.level;

endmodule : alcc_channel

// ---- src/alcc_top.sv ----
// Top: register port, shared 80 ms timebase and the two sensor channels
// Operation
// - Channel A filter field selects 80..10240 ms
// - Channel A forced read converts when allowed
// - Forced-read bit self-clears after valid results
// - Channel A forced read ignored with backlight on
// - Channel A dark/office results in bits 3/2
// - Channel A bits 1/0 enable dark/office comparators
// - Dark result has priority for backlight level
// - Channel B filter field selects 80..10240 ms
// - Channel B forced read converts, then self-clears
// - Channel B forced read ignored with backlight on
// - Channel B dark/office results in bits 3/2
// - Channel B bits 1/0 enable dark/office comparators
// - Below office threshold selects office level
// - Below dark threshold selects dark level
// - Above office threshold plus hysteresis selects daylight
// - Enabled sensor result refreshes once per filter window, every 80 ms times 2^filter_time_sel_a
`timescale 1ns/1ns
module alcc_top
    import alcc_pkg::*;
#(
    parameter int TICK_CYCLES = ALCC_PERIOD_CYC
)(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    output logic [7:0]                 reg_rdata,
    input  wire alcc_pkg::alcc_thr_s   thr,
    input  wire logic [12:0]           light_sensor_input_a,
    input  wire logic [12:0]           light_sensor_input_b,
    input  wire logic                  sensor_enable_a,
    input  wire logic                  sensor_enable_b,
    input  wire logic                  sinks_active,
    input  wire logic                  backlight_enable,
    output logic [12:0]                conv_result_a,
    output logic [12:0]                conv_result_b,
    output alcc_pkg::alcc_level_e      level_a,
    output alcc_pkg::alcc_level_e      level_b
);
    import alcc_pkg::*;

    typedef struct packed {
        logic [ALCC_TICK_W-1:0] tick_cnt;
        logic                   tick;
        logic [7:0]             rdata;
    } alcc_top_state_s;

    alcc_top_state_s s;
    alcc_top_state_s next_s;

    alcc_cfg_s   cfg     [ALCC_NUM_CH];
    logic [12:0] results [ALCC_NUM_CH];
    alcc_level_e levels  [ALCC_NUM_CH];
    logic [12:0] inputs  [ALCC_NUM_CH];
    logic        sen_en  [ALCC_NUM_CH];
    logic        wr_sel  [ALCC_NUM_CH];

    assign inputs[0] = light_sensor_input_a;
    assign inputs[1] = light_sensor_input_b;
    assign sen_en[0] = sensor_enable_a;
    assign sen_en[1] = sensor_enable_b;
    assign wr_sel[0] = reg_wr && (reg_addr == ALCC_OFS_CFG_A);
    assign wr_sel[1] = reg_wr && (reg_addr == ALCC_OFS_CFG_B);

    always_comb begin
        next_s      = s;
        next_s.tick = 1'b0;
        // Shared timebase keeps both channels sampling in step
        if (s.tick_cnt == ALCC_TICK_W'(TICK_CYCLES - 1)) begin
            next_s.tick_cnt = '0;
            next_s.tick     = 1'b1;
        end else begin
            next_s.tick_cnt = s.tick_cnt + ALCC_TICK_W'(1);
        end
        if (reg_rd) begin
            unique case (reg_addr)
                ALCC_OFS_CFG_A: next_s.rdata = cfg[0];
                ALCC_OFS_CFG_B: next_s.rdata = cfg[1];
                default:        next_s.rdata = ALCC_RDATA_UNMAP;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    for (genvar ch = 0; ch < ALCC_NUM_CH; ch++) begin : g_ch
        alcc_channel u_channel (
            .sys_clk            (sys_clk),
            .rst_n              (rst_n),
            .tick               (s.tick),
            .cfg_wr             (wr_sel[ch]),
            .cfg_wdata          (alcc_cfg_s'(reg_wdata)),
            .thr                (thr),
            .light_sensor_input (inputs[ch]),
            .sensor_enable      (sen_en[ch]),
            .sinks_active       (sinks_active),
            .backlight_enable   (backlight_enable),
            .cfg                (cfg[ch]),
            .conv_result        (results[ch]),
            .level              (levels[ch])
        );
    end

    assign reg_rdata     = s.rdata;
    assign conv_result_a = results[0];
    assign conv_result_b = results[1];
    assign level_a       = levels[0];
    assign level_b       = levels[1];

endmodule : alcc_top

// ---- verif/alcc_light_model.sv ----
// Light-sensor model: phototransistor codes settle a little after the bench asks
`timescale 1ns/1ns
module alcc_light_model (
    input  wire logic [12:0] want_a,
    input  wire logic [12:0] want_b,
    output logic [12:0]      light_sensor_input_a,
    output logic [12:0]      light_sensor_input_b
);
    // Settling delay keeps changes clear of the sampling edge
    assign #2 light_sensor_input_a = want_a;
    assign #2 light_sensor_input_b = want_b;
endmodule : alcc_light_model

// ---- verif/alcc_assertions.sv ----
// Checker: port-level properties of the light comparator block
`timescale 1ns/1ns
module alcc_assertions
    import alcc_pkg::*;
#(
    parameter int TICK_CYCLES = ALCC_PERIOD_CYC
)(
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [7:0]            reg_addr,
    input wire logic [7:0]            reg_wdata,
    input wire logic [7:0]            reg_rdata,
    input wire logic [12:0]           light_sensor_input_a,
    input wire logic [12:0]           light_sensor_input_b,
    input wire logic                  sensor_enable_a,
    input wire logic                  sensor_enable_b,
    input wire logic                  sinks_active,
    input wire logic                  backlight_enable,
    input wire logic [12:0]           conv_result_a,
    input wire logic [12:0]           conv_result_b,
    input wire alcc_pkg::alcc_level_e level_a,
    input wire alcc_pkg::alcc_level_e level_b
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence force_wr(logic [7:0] ofs, logic cond);
        reg_wr && reg_addr == ofs && reg_wdata[ALCC_POS_FORCE] && cond;
    endsequence
    // Read data is the byte from before the read edge, so compare with the old level
    property status_p(logic [7:0] ofs, alcc_level_e lvl);
        reg_rd && reg_addr == ofs |=> (reg_rdata[ALCC_POS_DARK_OUT] ? $past(lvl) == ALCC_LVL_DARK
            : $past(lvl) == (reg_rdata[ALCC_POS_OFF_OUT] ? ALCC_LVL_OFFICE : ALCC_LVL_DAYLIGHT));
    endproperty
    force_conv_a: assert property (
        force_wr(ALCC_OFS_CFG_A, 1'b1) ##1 (sinks_active && !backlight_enable && !sensor_enable_a)
        |=> conv_result_a == $past(light_sensor_input_a)) else $error("forced read a wrong");
    force_conv_b: assert property (
        force_wr(ALCC_OFS_CFG_B, 1'b1) ##1 (sinks_active && !backlight_enable && !sensor_enable_b)
        |=> conv_result_b == $past(light_sensor_input_b)) else $error("forced read b wrong");
    force_skip_a: assert property (
        force_wr(ALCC_OFS_CFG_A, backlight_enable) ##1 (backlight_enable && !sensor_enable_a)
        |=> $stable(conv_result_a)) else $error("ignored read a converted");
    force_skip_b: assert property (
        force_wr(ALCC_OFS_CFG_B, backlight_enable) ##1 (backlight_enable && !sensor_enable_b)
        |=> $stable(conv_result_b)) else $error("ignored read b converted");
    status_lvl_a: assert property (status_p(ALCC_OFS_CFG_A, level_a))
        else $error("status a disagrees with level");
    status_lvl_b: assert property (status_p(ALCC_OFS_CFG_B, level_b))
        else $error("status b disagrees with level");
    dark_off_a: assert property (
        reg_wr && reg_addr == ALCC_OFS_CFG_A && !reg_wdata[ALCC_POS_DARK_EN]
        |=> level_a != ALCC_LVL_DARK) else $error("disabled dark comparator acts");
    both_off_b: assert property (
        reg_wr && reg_addr == ALCC_OFS_CFG_B && reg_wdata[1:0] == 2'b00
        |=> level_b == ALCC_LVL_DAYLIGHT) else $error("disabled comparators act");
endmodule : alcc_assertions
bind alcc_top alcc_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .light_sensor_input_a(light_sensor_input_a), .light_sensor_input_b(light_sensor_input_b),
    .sensor_enable_a(sensor_enable_a), .sensor_enable_b(sensor_enable_b),
    .sinks_active(sinks_active), .backlight_enable(backlight_enable),
    .conv_result_a(conv_result_a), .conv_result_b(conv_result_b),
    .level_a(level_a), .level_b(level_b));

// ---- verif/alcc_top_tb.sv ----
// Testbench: register access, forced reads, comparators and filter windows
`timescale 1ns/1ns
module alcc_top_tb;
    import alcc_pkg::*;
    localparam int TICK = 8;
    logic        sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        sinks_active = 1'b0, backlight_enable = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [1:0]  sens_en = 2'b00;
    logic [12:0] want [2] = '{13'h0000, 13'h0000};
    logic [12:0] res [2] = '{13'h0000, 13'h0000};
    logic [1:0]  trip [2] = '{2'b00, 2'b00};
    logic [12:0] light_a, light_b, conv_a, conv_b;
    alcc_level_e level_a, level_b;
    alcc_thr_s   thr = '{8'h64, 8'h14, 8'h28, 8'h0A};
    int          errors = 0;
    int          n_compared = 0;
    always #4 sys_clk = ~sys_clk;
    alcc_top #(.TICK_CYCLES(TICK)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .thr(thr),
        .light_sensor_input_a(light_a), .light_sensor_input_b(light_b),
        .sensor_enable_a(sens_en[0]), .sensor_enable_b(sens_en[1]),
        .sinks_active(sinks_active), .backlight_enable(backlight_enable),
        .conv_result_a(conv_a), .conv_result_b(conv_b), .level_a(level_a), .level_b(level_b));
    alcc_light_model u_light (.want_a(want[0]), .want_b(want[1]),
        .light_sensor_input_a(light_a), .light_sensor_input_b(light_b));
    task automatic chk_res(input logic [12:0] got, input logic [12:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_res
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        chk_res({5'h00, got}, {5'h00, exp});
    endtask : chk_reg
    function automatic logic upd(logic old, logic [12:0] v, logic [7:0] t, logic [7:0] h);
        return (v < t) ? 1'b1 : (v > t + h) ? 1'b0 : old;
    endfunction : upd
    function automatic logic [7:0] lvl(logic [1:0] tr);
        return {6'h00, tr[1] ? ALCC_LVL_DARK : tr[0] ? ALCC_LVL_OFFICE : ALCC_LVL_DAYLIGHT};
    endfunction : lvl
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd
    task automatic convert(input int ch, input logic [12:0] v, input logic [1:0] en);
        res[ch] = v;
        trip[ch][1] = en[1] & upd(trip[ch][1], v, thr.dark_threshold, thr.dark_hysteresis);
        trip[ch][0] = en[0] & upd(trip[ch][0], v, thr.office_threshold, thr.office_hysteresis);
    endtask : convert
    task automatic check_ch(input int ch, input logic [3:0] hi, input logic [1:0] en);
        logic [7:0] d;
        rd(ch ? ALCC_OFS_CFG_B : ALCC_OFS_CFG_A, d);
        chk_reg(d, {hi, trip[ch], en});
        chk_res(ch ? conv_b : conv_a, res[ch]);
        chk_reg({6'h00, ch ? level_b : level_a}, lvl(trip[ch]));
    endtask : check_ch
    // Bits 3:2 are written as ones to show they are read-only
    task automatic force_rd(input int ch, input logic [12:0] v, input logic [1:0] en,
                            input logic sk, input logic bl);
        want[ch] = v;
        sinks_active = sk;
        backlight_enable = bl;
        @(negedge sys_clk);
        wr(ch ? ALCC_OFS_CFG_B : ALCC_OFS_CFG_A, {6'h07, en});
        trip[ch] &= en;
        @(negedge sys_clk);
        if (!sk && !bl) begin
            check_ch(ch, 4'h1, en);
            sinks_active = 1'b1;
            @(negedge sys_clk);
        end
        if (!bl) convert(ch, v, en);
        check_ch(ch, 4'h0, en);
    endtask : force_rd
    task automatic filter_time_sel_a_run(input int ch, input logic [2:0] f);
        logic [12:0] v;
        v = res[ch] + 13'(1 + $urandom_range(0, 150));
        want[ch] = v;
        @(negedge sys_clk);
        wr(ch ? ALCC_OFS_CFG_B : ALCC_OFS_CFG_A, {f, 5'h03});
        sens_en[ch] = 1'b1;
        repeat ((2 ** f - 1) * TICK) @(negedge sys_clk);
        chk_res(ch ? conv_b : conv_a, res[ch]);
        repeat (TICK + 1) @(negedge sys_clk);
        convert(ch, v, 2'b11);
        check_ch(ch, {f, 1'b0}, 2'b11);
        sens_en[ch] = 1'b0;
    endtask : filter_time_sel_a_run
    task automatic summarize;
        $display("errors=%0d n_compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    initial begin
        logic [7:0] d;
        int cv [6] = '{0, 45, 51, 110, 121, 39};
        void'($urandom(32'h1619));
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        for (logic [7:0] a = 8'h1B; a < 8'h1E; a++) begin
            rd(a, d);
            chk_reg(d, ALCC_CFG_RESET);
            // Idle cycle so the read strobe is not dropped and raised in one step
            @(negedge sys_clk);
        end
        wr(8'h1D, 8'hFF);
        for (int ch = 0; ch < 2; ch++) begin
            for (int f = 0; f < 8; f++) filter_time_sel_a_run(ch, 3'(f));
            foreach (cv[i]) force_rd(ch, 13'(cv[i]), 2'b11, 1'b1, 1'b0);
        end
        force_rd(0, 13'h0000, 2'b01, 1'b1, 1'b0);
        force_rd(1, 13'h0000, 2'b00, 1'b1, 1'b0);
        force_rd(0, 13'h1FFF, 2'b11, 1'b1, 1'b1);
        force_rd(1, 13'h0005, 2'b11, 1'b0, 1'b0);
        // Mid-run reset: configuration, results and levels must return to idle
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        res = '{13'h0000, 13'h0000};
        trip = '{2'b00, 2'b00};
        @(negedge sys_clk);
        for (int ch = 0; ch < 2; ch++) begin
            check_ch(ch, 4'h0, 2'b00);
            @(negedge sys_clk);
        end
        for (int i = 0; i < 40; i++) begin
            // Thresholds move now and then; office pair kept within its legal sum
            if (i % 8 == 0) begin
                thr = {8'($urandom_range(60, 200)), 8'($urandom_range(0, 50)),
                       8'($urandom_range(0, 59)), 8'($urandom_range(0, 40))};
            end
            force_rd($urandom_range(0, 1), 13'($urandom_range(0, 160)), 2'($urandom_range(0, 3)),
                     1'($urandom_range(0, 1)), 1'($urandom_range(0, 1)));
        end
        summarize();
    end
    initial begin
        #300000;
        errors++;
        summarize();
    end
endmodule : alcc_top_tb
